/* File: core/nfs_bus_if.sv */
/*
  Internal carrier between the sequencer and its single bus-cycle engine.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface nfs_bus_if;
  logic req;
  logic wr;
  logic [19:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : nfs_bus_if
`default_nettype wire

/* File: core/nfs_cycle.sv */
/*
  One flash bus cycle (read or write) on the parallel pins.
  Assumes the flash samples address on the later falling strobe and data on
  the earlier rising strobe; chip select and write strobe move together here.
*/
`timescale 1ns/1ns
`default_nettype none
module nfs_cycle
  import nfs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Sequencer side
  nfs_bus_if.eng bus,
  // Flash pins
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [19:0] addr,
  output logic [15:0] dq_o,
  output logic dq_oe,
  input wire logic [15:0] dq_i
);
  typedef enum logic [1:0] {CY_IDLE, CY_ACT, CY_REC} nfs_cy_t;
  nfs_cy_t st_ff, nxt_st;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic ce_n_ff, nxt_ce_n, we_n_ff, nxt_we_n, oe_n_ff, nxt_oe_n, oe_ff, nxt_oe, done_ff, nxt_done;
  logic [19:0] a_ff, nxt_a;
  logic [15:0] d_ff, nxt_d, r_ff, nxt_r;

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_ce_n = ce_n_ff;
    nxt_we_n = we_n_ff;
    nxt_oe_n = oe_n_ff;
    nxt_oe = oe_ff;
    nxt_a = a_ff;
    nxt_d = d_ff;
    nxt_r = r_ff;
    nxt_done = 1'b0;
    case (st_ff)
      CY_IDLE: begin
        if (bus.req) begin
          nxt_a = bus.addr;
          nxt_d = bus.wdata;
          nxt_ce_n = 1'b0;
          nxt_we_n = !bus.wr;
          nxt_oe_n = bus.wr;
          nxt_oe = bus.wr;
          nxt_cnt = CNT_W'(BUS_PHASE_CYC);
          nxt_st = CY_ACT;
        end
      end
      CY_ACT: begin
        if (cnt_ff == '0) begin
          nxt_r = dq_i;
          nxt_ce_n = 1'b1;
          nxt_we_n = 1'b1;
          nxt_oe_n = 1'b1;
          nxt_cnt = CNT_W'(BUS_PHASE_CYC);
          nxt_st = CY_REC;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      CY_REC: begin
        if (cnt_ff == '0) begin
          nxt_oe = 1'b0;
          nxt_done = 1'b1;
          nxt_st = CY_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      default: nxt_st = CY_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= CY_IDLE;
      cnt_ff <= '0;
      ce_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      oe_ff <= 1'b0;
      a_ff <= '0;
      d_ff <= '0;
      r_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      ce_n_ff <= nxt_ce_n;
      we_n_ff <= nxt_we_n;
      oe_n_ff <= nxt_oe_n;
      oe_ff <= nxt_oe;
      a_ff <= nxt_a;
      d_ff <= nxt_d;
      r_ff <= nxt_r;
      done_ff <= nxt_done;
    end
  end

  assign ce_n = ce_n_ff;
  assign we_n = we_n_ff;
  assign oe_n = oe_n_ff;
  assign addr = a_ff;
  assign dq_o = d_ff;
  assign dq_oe = oe_ff;
  assign bus.done = done_ff;
  assign bus.rdata = r_ff;
endmodule : nfs_cycle
`default_nettype wire

/* File: core/nfs_host.sv */
/*
  Host controller for a parallel NOR flash: issues reset, read, identifier
  read, program, chip erase and sector erase sequences; polls status after program and erase.
  Assumes one 125 MHz clock and flash pins taken as synchronous to it.
*/
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Host waits reset_high_to_read after clear release before any access.
// - After a timeout failure host writes F0H, then a fresh valid command.
// - Erase is six writes: unlock pair, 80H, unlock pair, 10H or 30H.
// - Host writes reset after timeout or when leaving identifier mode.
// - Each further sector load must start within 50us of previous write.
// - Program is four writes: unlock pair, A0H, then address and data.
// - Unlock writes use 555H and 2AAH in word mode on low bits.
module nfs_host
  import nfs_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // User command port
  input wire logic CMD_VALID,
  input wire logic [2:0] CMD_OP,
  input wire logic [19:0] CMD_ADDR,
  input wire logic [15:0] CMD_DATA,
  input wire logic BYTE_MODE,
  output logic CMD_READY,
  output logic RSP_VALID,
  output logic [15:0] RSP_DATA,
  output logic RSP_FAIL,
  // Flash pins
  output logic FL_CE_N,
  output logic FL_WE_N,
  output logic FL_OE_N,
  output logic FL_HW_CLEAR_N,
  output logic [19:0] FL_ADDR,
  output logic [15:0] FL_DQ_O,
  output logic FL_DQ_OE,
  input wire logic [15:0] FL_DQ_I,
  input wire logic FL_READY_BUSY_N
);
  typedef enum logic [3:0] {
    S_IDLE, S_WRITE, S_READ, S_POLL, S_CHECK, S_ABORT, S_CLR_LOW, S_CLR_WAIT, S_DONE
  } nfs_st_t;

  nfs_bus_if bus ();
  nfs_st_t st_ff, nxt_st;
  nfs_op_t op_ff, nxt_op;
  logic [2:0] step_ff, nxt_step;
  logic [19:0] addr_ff, nxt_addr;
  logic [15:0] data_ff, nxt_data, prev_ff, nxt_prev;
  logic first_ff, nxt_first, byte_ff, nxt_byte;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic ready_ff, nxt_ready, rv_ff, nxt_rv, fail_ff, nxt_fail, clr_n_ff, nxt_clr_n;
  logic [15:0] rd_ff, nxt_rd;
  logic req_ff, nxt_req, wr_ff, nxt_wr;
  logic [19:0] baddr_ff, nxt_baddr;
  logic [15:0] bdata_ff, nxt_bdata;

  function automatic logic [19:0] unlock_addr(input logic b, input logic bmode);
    if (bmode) begin
      return b ? UNLOCK_B_BYTE : UNLOCK_A_BYTE;
    end
    return b ? UNLOCK_B_WORD : UNLOCK_A_WORD;
  endfunction : unlock_addr

  // Sequence table: address and data of write number s for the current op.
  function automatic logic [35:0] seq_word(input nfs_op_t op, input logic [2:0] s,
      input logic bm, input logic [19:0] a, input logic [15:0] d);
    logic [7:0] cmd;
    cmd = 8'h00;
    case (s)
      3'd0: return {unlock_addr(1'b0, bm), 8'h00, CMD_UNLOCK1};
      3'd1: return {unlock_addr(1'b1, bm), 8'h00, CMD_UNLOCK2};
      3'd2: begin
        case (op)
          OP_PROG: cmd = CMD_PROG;
          OP_ID_READ: cmd = CMD_ID;
          default: cmd = CMD_ERASE;
        endcase
        return {unlock_addr(1'b0, bm), 8'h00, cmd};
      end
      3'd3: begin
        if (op == OP_PROG) begin
          return {a, d};
        end
        return {unlock_addr(1'b0, bm), 8'h00, CMD_UNLOCK1};
      end
      3'd4: return {unlock_addr(1'b1, bm), 8'h00, CMD_UNLOCK2};
      default: begin
        if (op == OP_SECTOR_ERASE) begin
          return {a, 8'h00, CMD_SECTOR};
        end
        return {unlock_addr(1'b0, bm), 8'h00, CMD_CHIP};
      end
    endcase
  endfunction : seq_word

  function automatic logic [2:0] last_step(input nfs_op_t op);
    case (op)
      OP_PROG: return 3'd3;
      OP_ID_READ: return 3'd2;
      OP_CHIP_ERASE, OP_SECTOR_ERASE: return 3'd5;
      default: return 3'd0;
    endcase
  endfunction : last_step

  nfs_cycle u_cycle (
    .clk(CLK),
    .srst(SRST),
    .bus(bus.eng),
    .ce_n(FL_CE_N),
    .we_n(FL_WE_N),
    .oe_n(FL_OE_N),
    .addr(FL_ADDR),
    .dq_o(FL_DQ_O),
    .dq_oe(FL_DQ_OE),
    .dq_i(FL_DQ_I)
  );

  assign bus.req = req_ff;
  assign bus.wr = wr_ff;
  assign bus.addr = baddr_ff;
  assign bus.wdata = bdata_ff;

  always_comb begin
    logic [35:0] w;
    w = seq_word(op_ff, step_ff, byte_ff, addr_ff, data_ff);
    nxt_st = st_ff;
    nxt_op = op_ff;
    nxt_step = step_ff;
    nxt_addr = addr_ff;
    nxt_data = data_ff;
    nxt_prev = prev_ff;
    nxt_first = first_ff;
    nxt_byte = byte_ff;
    nxt_cnt = cnt_ff;
    nxt_ready = 1'b0;
    nxt_rv = 1'b0;
    nxt_fail = fail_ff;
    nxt_rd = rd_ff;
    nxt_clr_n = clr_n_ff;
    nxt_req = 1'b0;
    nxt_wr = wr_ff;
    nxt_baddr = baddr_ff;
    nxt_bdata = bdata_ff;
    case (st_ff)
      S_IDLE: begin
        nxt_ready = 1'b1;
        if (CMD_VALID && ready_ff) begin
          nxt_ready = 1'b0;
          nxt_op = nfs_op_t'(CMD_OP);
          nxt_addr = CMD_ADDR;
          nxt_data = CMD_DATA;
          nxt_byte = BYTE_MODE;
          nxt_step = 3'd0;
          nxt_fail = 1'b0;
          case (nfs_op_t'(CMD_OP))
            OP_READ: nxt_st = S_READ;
            OP_HW_RESET: begin
              nxt_clr_n = 1'b0;
              nxt_cnt = CNT_W'(RESET_PULSE_CYC);
              nxt_st = S_CLR_LOW;
            end
            default: nxt_st = S_WRITE;
          endcase
        end
      end
      S_WRITE: begin
        if (!req_ff && !bus.done) begin
          nxt_req = 1'b1;
          nxt_wr = 1'b1;
          nxt_baddr = (op_ff == OP_RESET) ? addr_ff : w[35:16];
          nxt_bdata = (op_ff == OP_RESET) ? {8'h00, CMD_RESET} : w[15:0];
          nxt_st = S_CHECK;
        end
      end
      S_CHECK: begin
        if (bus.done) begin
          if (step_ff == last_step(op_ff) || op_ff == OP_RESET) begin
            case (op_ff)
              OP_ID_READ: nxt_st = S_READ;
              OP_PROG, OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
                nxt_first = 1'b1;
                nxt_st = S_POLL;
              end
              default: nxt_st = S_DONE;
            endcase
          end else begin
            nxt_step = step_ff + 3'd1;
            nxt_st = S_WRITE;
          end
        end
      end
      S_READ: begin
        if (!req_ff && !bus.done) begin
          nxt_req = 1'b1;
          nxt_wr = 1'b0;
          nxt_baddr = (op_ff == OP_ID_READ) ? (addr_ff[0] ? ID_DEVICE_ADDR : ID_MANUF_ADDR)
                                            : addr_ff;
        end else if (bus.done) begin
          nxt_rd = bus.rdata;
          if (op_ff == OP_ID_READ) begin
            nxt_op = OP_RESET;
            nxt_st = S_WRITE;
          end else begin
            nxt_st = S_DONE;
          end
        end
      end
      S_POLL: begin
        if (!req_ff && !bus.done) begin
          nxt_req = 1'b1;
          nxt_wr = 1'b0;
          nxt_baddr = addr_ff;
        end else if (bus.done) begin
          nxt_prev = bus.rdata;
          nxt_first = 1'b0;
          if (!first_ff) begin
            if (bus.rdata[TOGGLE_BIT] == prev_ff[TOGGLE_BIT] && FL_READY_BUSY_N) begin
              nxt_rd = bus.rdata;
              nxt_fail = (op_ff == OP_PROG) && (bus.rdata != data_ff) && !byte_ff;
              nxt_st = S_DONE;
            end else if (prev_ff[TIMEOUT_BIT] && bus.rdata[TIMEOUT_BIT]) begin
              nxt_fail = 1'b1;
              nxt_st = S_ABORT;
            end
          end
        end
      end
      S_ABORT: begin
        nxt_op = OP_RESET;
        nxt_st = S_WRITE;
      end
      S_CLR_LOW: begin
        if (cnt_ff == '0) begin
          nxt_clr_n = 1'b1;
          nxt_cnt = CNT_W'(RESET_HIGH_CYC);
          nxt_st = S_CLR_WAIT;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      S_CLR_WAIT: begin
        if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - 1'b1;
        end else if (FL_READY_BUSY_N) begin
          nxt_st = S_DONE;
        end
      end
      S_DONE: begin
        nxt_rv = 1'b1;
        nxt_st = S_IDLE;
      end
      default: nxt_st = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_ff <= S_IDLE;
      op_ff <= OP_READ;
      step_ff <= 3'd0;
      addr_ff <= '0;
      data_ff <= '0;
      prev_ff <= '0;
      first_ff <= 1'b0;
      byte_ff <= 1'b0;
      cnt_ff <= '0;
      ready_ff <= 1'b0;
      rv_ff <= 1'b0;
      fail_ff <= 1'b0;
      rd_ff <= '0;
      clr_n_ff <= 1'b1;
      req_ff <= 1'b0;
      wr_ff <= 1'b0;
      baddr_ff <= '0;
      bdata_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      op_ff <= nxt_op;
      step_ff <= nxt_step;
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
      prev_ff <= nxt_prev;
      first_ff <= nxt_first;
      byte_ff <= nxt_byte;
      cnt_ff <= nxt_cnt;
      ready_ff <= nxt_ready;
      rv_ff <= nxt_rv;
      fail_ff <= nxt_fail;
      rd_ff <= nxt_rd;
      clr_n_ff <= nxt_clr_n;
      req_ff <= nxt_req;
      wr_ff <= nxt_wr;
      baddr_ff <= nxt_baddr;
      bdata_ff <= nxt_bdata;
    end
  end

  assign CMD_READY = ready_ff;
  assign RSP_VALID = rv_ff;
  assign RSP_DATA = rd_ff;
  assign RSP_FAIL = fail_ff;
  assign FL_HW_CLEAR_N = clr_n_ff;
endmodule : nfs_host
`default_nettype wire

/* File: core/nfs_pkg.sv */
/*
  Constants for the NOR flash command sequencer host controller: command codes,
  unlock addresses, bus timing counts and status bit positions.
  Assumes a 125 MHz system clock and a word/byte switchable parallel NOR flash.
*/
package nfs_pkg;
  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int RESET_PULSE_MIN_NS = 500;
  localparam int RESET_HIGH_TO_READ_NS = 50;
  localparam int SECTOR_WINDOW_US = 50;
  localparam int BUS_PHASE_NS = 70;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_HIGH_CYC = (RESET_HIGH_TO_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_PHASE_CYC = (BUS_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest time: round down so the next sector load starts inside the window.
  localparam int SECTOR_WINDOW_CYC = (SECTOR_WINDOW_US * 1000) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] CMD_PROG = 8'hA0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_CHIP = 8'h10;
  localparam logic [7:0] CMD_SECTOR = 8'h30;

  // ****************************************************************
  // Unlock addresses (low bits) and widths
  // ****************************************************************
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam logic [19:0] UNLOCK_A_WORD = 20'h0_0555;
  localparam logic [19:0] UNLOCK_B_WORD = 20'h0_02AA;
  localparam logic [19:0] UNLOCK_A_BYTE = 20'h0_0AAA;
  localparam logic [19:0] UNLOCK_B_BYTE = 20'h0_0555;
  localparam logic [19:0] ID_MANUF_ADDR = 20'h0_0000;
  localparam logic [19:0] ID_DEVICE_ADDR = 20'h0_0001;

  // ****************************************************************
  // Status bit positions
  // ****************************************************************
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int TIMEOUT_BIT = 5;

  // ****************************************************************
  // User operations
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_READ, OP_RESET, OP_PROG, OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_ID_READ, OP_HW_RESET
  } nfs_op_t;
endpackage : nfs_pkg

/* File: tb/nfs_flash_model.sv */
/*
  Behavioural parallel NOR flash of 16 words for the host bench.
  Assumes strobes that move on the bench clock.
*/
`timescale 1ns/1ns
`default_nettype none
module nfs_flash_model
  import nfs_pkg::*;
#(
  parameter int BUSY_CYC = 300,
  parameter int WIN_CYC = 6250,
  parameter int RECOV_CYC = 20,
  // Arbitrary identification values.
  parameter logic [15:0] MAKER_ID = 16'h0011,
  parameter logic [15:0] PART_ID = 16'h0022
)(
  // Clock and fault control
  input wire logic clk,
  input wire logic fail_erase,
  // Flash pins
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic clear_n,
  input wire logic byte_mode,
  input wire logic [19:0] addr,
  input wire logic [15:0] din,
  output logic [15:0] dout,
  output logic busy_low
);
  logic [15:0] mem [0:15];
  logic [15:0] last = 16'h0000;
  logic [15:0] pd = 16'h0000;
  logic [19:0] la = 20'h0_0000;
  logic [19:0] pa = 20'h0_0000;
  logic [2:0] step = 3'h0;
  logic wr_q = 1'b1, oe_q = 1'b1, idm = 1'b0, tog = 1'b0, to = 1'b0;
  logic prg = 1'b0, ers = 1'b0, chip = 1'b0;
  int cnt = 0;
  int rec = 0;
  wire wr = ce_n | we_n;
  wire rd_on = !ce_n && !oe_n && clear_n;
  wire busy = prg | ers;
  wire [7:0] c = din[7:0];
  wire [19:0] ua = byte_mode ? UNLOCK_A_BYTE : UNLOCK_A_WORD;
  wire [19:0] ub = byte_mode ? UNLOCK_B_BYTE : UNLOCK_B_WORD;
  wire [15:0] st = {8'h00, prg & ~pd[7], tog, to, 5'h00};
  assign dout = !rd_on ? ~last : busy ? st : idm ? (addr[0] ? PART_ID : MAKER_ID) : mem[addr[3:0]];
  assign busy_low = busy || rec != 0;
  initial for (int i = 0; i < 16; i++) mem[i] = 16'hC3A0 | 16'(i);
  always @(posedge clk) begin
    wr_q <= wr;
    oe_q <= oe_n;
    if (rd_on) last <= dout;
    if (rec != 0) rec <= rec - 1;
    if (busy && oe_n && !oe_q) tog <= ~tog;
    if (wr_q && !wr) la <= addr;
    if (busy && !to) begin
      if (cnt > 0) cnt <= cnt - 1;
      else if (ers && fail_erase) to <= 1'b1;
      else begin
        prg <= 1'b0;
        ers <= 1'b0;
        if (prg) mem[pa[3:0]] <= mem[pa[3:0]] & pd;
        for (int i = 0; i < 16; i++) if (ers && (chip || i[3:2] == pa[3:2])) mem[i] <= 16'hFFFF;
      end
    end
    if (!wr_q && wr) begin
      if (busy) begin
        if (to && c == CMD_RESET) begin
          prg <= 1'b0;
          ers <= 1'b0;
          to <= 1'b0;
        end else if (ers && !chip && cnt > BUSY_CYC && c != CMD_SECTOR) begin
          ers <= 1'b0;
        end
      end else if (c == CMD_RESET && step != 3'h6) begin
        step <= 3'h0;
        idm <= 1'b0;
      end else begin
        step <= 3'h0;
        case (step)
          3'h0: if (la == ua && c == CMD_UNLOCK1) step <= 3'h1;
          3'h1: if (la == ub && c == CMD_UNLOCK2) step <= 3'h2;
          3'h2: if (la == ua) begin
            if (c == CMD_ID) idm <= 1'b1;
            if (c == CMD_PROG) step <= 3'h6;
            if (c == CMD_ERASE) step <= 3'h3;
          end
          3'h3: if (la == ua && c == CMD_UNLOCK1) step <= 3'h4;
          3'h4: if (la == ub && c == CMD_UNLOCK2) step <= 3'h5;
          3'h5: begin
            chip <= c == CMD_CHIP;
            pa <= la;
            cnt <= (c == CMD_CHIP) ? BUSY_CYC : WIN_CYC + BUSY_CYC;
            ers <= c == CMD_CHIP || c == CMD_SECTOR;
          end
          default: begin
            pa <= la;
            pd <= din;
            cnt <= BUSY_CYC;
            prg <= 1'b1;
          end
        endcase
      end
    end
    if (!clear_n) begin
      if (busy) rec <= RECOV_CYC;
      prg <= 1'b0;
      ers <= 1'b0;
      to <= 1'b0;
      step <= 3'h0;
      idm <= 1'b0;
    end
  end
endmodule : nfs_flash_model
`default_nettype wire

/* File: tb/nfs_host_bench.sv */
/*
  Self-checking bench: host controller driving a flash model.
  Assumes one command at a time on the user port.
*/
`timescale 1ns/1ns
`default_nettype none
module nfs_host_bench;
  import nfs_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [19:0] cmd_addr = 20'h0_0000;
  logic [15:0] cmd_data = 16'h0000;
  logic byte_mode = 1'b0;
  logic fail_erase = 1'b0;
  logic cmd_ready, rsp_valid, rsp_fail, ce_n, we_n, oe_n, clr_n, dq_oe, ry_low;
  logic [15:0] rsp_data, dq_o, mdq;
  logic [19:0] fl_addr;
  int err_total = 0;
  int comparisons = 0;
  // Pull-up on the open-drain busy line.
  wire ry_n = !ry_low;
  wire [15:0] dq_i = dq_oe ? dq_o : mdq;
  nfs_host nfs_host_i (.CLK(clk), .SRST(srst), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
    .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .BYTE_MODE(byte_mode), .CMD_READY(cmd_ready),
    .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_FAIL(rsp_fail), .FL_CE_N(ce_n),
    .FL_WE_N(we_n), .FL_OE_N(oe_n), .FL_HW_CLEAR_N(clr_n), .FL_ADDR(fl_addr), .FL_DQ_O(dq_o),
    .FL_DQ_OE(dq_oe), .FL_DQ_I(dq_i), .FL_READY_BUSY_N(ry_n));
  nfs_flash_model nfs_flash_model_i (.clk(clk), .fail_erase(fail_erase), .ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .clear_n(clr_n), .byte_mode(byte_mode), .addr(fl_addr),
    .din(dq_o), .dout(mdq), .busy_low(ry_low));
  initial forever #4 clk = ~clk;
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic run(input nfs_op_t op, input logic [19:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("response", 16'h0001, {15'h0000, rsp_valid});
  endtask : run
  task automatic t_power_up();
    run(OP_READ, 20'h0_0003, 16'h0000);
    check("array read", 16'hC3A3, rsp_data);
    $display("power-up read test done");
  endtask : t_power_up
  task automatic t_prog();
    run(OP_PROG, 20'h0_0002, 16'h0302);
    check("prog fail", 16'h0000, {15'h0000, rsp_fail});
    run(OP_READ, 20'h0_0002, 16'h0000);
    check("prog data", 16'h0302, rsp_data);
    run(OP_PROG, 20'h0_0002, 16'hFFFF);
    check("reprog fail", 16'h0001, {15'h0000, rsp_fail});
    $display("program test done");
  endtask : t_prog
  task automatic t_id();
    run(OP_ID_READ, 20'h0_0000, 16'h0000);
    check("maker code", 16'h0011, rsp_data);
    run(OP_ID_READ, 20'h0_0001, 16'h0000);
    check("part code", 16'h0022, rsp_data);
    run(OP_RESET, 20'h0_0ABC, 16'h0000);
    check("reset fail", 16'h0000, {15'h0000, rsp_fail});
    run(OP_READ, 20'h0_0001, 16'h0000);
    check("read after id", 16'hC3A1, rsp_data);
    $display("id test done");
  endtask : t_id
  task automatic t_erase();
    run(OP_SECTOR_ERASE, 20'h0_0004, 16'h0000);
    run(OP_READ, 20'h0_0005, 16'h0000);
    check("sector erased", 16'hFFFF, rsp_data);
    run(OP_READ, 20'h0_0008, 16'h0000);
    check("outside sector", 16'hC3A8, rsp_data);
    fail_erase = 1'b1;
    run(OP_CHIP_ERASE, 20'h0_0000, 16'h0000);
    check("timeout fail", 16'h0001, {15'h0000, rsp_fail});
    fail_erase = 1'b0;
    run(OP_READ, 20'h0_0008, 16'h0000);
    check("read after abort", 16'hC3A8, rsp_data);
    run(OP_CHIP_ERASE, 20'h0_0000, 16'h0000);
    check("erase fail", 16'h0000, {15'h0000, rsp_fail});
    run(OP_READ, 20'h0_0008, 16'h0000);
    check("chip erased", 16'hFFFF, rsp_data);
    $display("erase test done");
  endtask : t_erase
  task automatic t_byte_clear();
    byte_mode = 1'b1;
    run(OP_PROG, 20'h0_0009, 16'h0033);
    byte_mode = 1'b0;
    run(OP_HW_RESET, 20'h0_0000, 16'h0000);
    run(OP_READ, 20'h0_0009, 16'h0000);
    check("byte prog", 16'h0021, rsp_data);
    $display("byte and clear test done");
  endtask : t_byte_clear
  task automatic wrap_up();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (8) @(posedge clk);
    #1;
    srst = 1'b0;
    t_power_up();
    t_prog();
    t_id();
    t_byte_clear();
    t_erase();
    wrap_up();
  end
  initial begin
    #600000;
    err_total++;
    wrap_up();
  end
endmodule : nfs_host_bench
`default_nettype wire

/* File: tb/nfs_host_chk.sv */
/*
  Port checks for the NOR flash host controller.
  Assumes one clock domain; bound below.
*/
`timescale 1ns/1ns
`default_nettype none
module nfs_host_chk
  import nfs_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // User side
  input wire logic BYTE_MODE,
  input wire logic CMD_READY,
  input wire logic RSP_VALID,
  // Flash side
  input wire logic FL_CE_N,
  input wire logic FL_WE_N,
  input wire logic FL_OE_N,
  input wire logic FL_HW_CLEAR_N,
  input wire logic [19:0] FL_ADDR,
  input wire logic [15:0] FL_DQ_O,
  input wire logic FL_DQ_OE,
  input wire logic FL_READY_BUSY_N
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  logic [15:0] low_cnt_ff;
  logic [15:0] nxt_low_cnt;
  always_comb nxt_low_cnt = FL_HW_CLEAR_N ? 16'h0000 : low_cnt_ff + 16'h0001;
  always_ff @(posedge CLK) low_cnt_ff <= SRST ? 16'h0000 : nxt_low_cnt;
  wire [19:0] ua = BYTE_MODE ? UNLOCK_A_BYTE : UNLOCK_A_WORD;
  wire [19:0] ub = BYTE_MODE ? UNLOCK_B_BYTE : UNLOCK_B_WORD;
  sequence s_wr(logic [7:0] d);
    $fell(FL_WE_N) && FL_DQ_O[7:0] == d;
  endsequence
  a_dq_gated: assert property (FL_DQ_OE |-> FL_OE_N)
    else $error("data driven while output gate low");
  a_write_strobes: assert property (!FL_WE_N |-> !FL_CE_N && FL_OE_N)
    else $error("write strobe without select or with gate low");
  a_write_hold: assert property ($fell(FL_WE_N) |=> (!FL_WE_N && $stable(FL_ADDR) && $stable(FL_DQ_O))[*8])
    else $error("write cycle not held");
  a_clear_width: assert property ($rose(FL_HW_CLEAR_N) |-> low_cnt_ff >= 16'h003F)
    else $error("clear pulse too short");
  a_clear_quiet: assert property (!FL_HW_CLEAR_N |-> FL_CE_N && !FL_DQ_OE)
    else $error("bus access during clear");
  a_read_gap: assert property ($rose(FL_HW_CLEAR_N) |-> FL_CE_N[*7])
    else $error("access too soon after clear");
  a_unlock_first: assert property (s_wr(CMD_UNLOCK1) |-> FL_ADDR == ua)
    else $error("first unlock address wrong");
  a_unlock_second: assert property (s_wr(CMD_UNLOCK2) |-> FL_ADDR == ub)
    else $error("second unlock address wrong");
  a_erase_order: assert property (s_wr(CMD_ERASE) |-> ##[1:60] s_wr(CMD_UNLOCK1))
    else $error("erase setup not followed by unlock");
  a_done_ready: assert property (RSP_VALID |-> FL_READY_BUSY_N ##1 !RSP_VALID ##[0:1] CMD_READY)
    else $error("response while flash busy or not one cycle");
endmodule : nfs_host_chk
bind nfs_host nfs_host_chk nfs_host_chk_i (.CLK(CLK), .SRST(SRST), .BYTE_MODE(BYTE_MODE),
  .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .FL_CE_N(FL_CE_N), .FL_WE_N(FL_WE_N),
  .FL_OE_N(FL_OE_N), .FL_HW_CLEAR_N(FL_HW_CLEAR_N), .FL_ADDR(FL_ADDR), .FL_DQ_O(FL_DQ_O),
  .FL_DQ_OE(FL_DQ_OE), .FL_READY_BUSY_N(FL_READY_BUSY_N));
`default_nettype wire
